/* File: core/rpch_core.sv */
// Peripheral-control command interpreter of a card reader.
// Assumes the transport layer has already removed the escape wrapper
// (code 6b on the wireless link, class escape on USB) and presents the
// request bytes one at a time, framed by i_req_last.
//
// Operation
// [RULE1] Requests arrive inside the wireless or USB escape wrapper.
// [RULE2] Byte 0 opcode, byte 1 payload count, payload from byte 2.
// [RULE3] Serial request 02h/00h replies 82h, serial size, serial bytes.
// [RULE4] Challenge request 03h/00h replies 83h, 10h, sixteen random bytes.
// [RULE5] Host encrypts challenge under master key with AES.
// [RULE6] Challenge served only over the wireless link.
// [RULE7] Version request 04h/00h replies 84h, length, ASCII version.
// [RULE8] Key rewrite is 07h with 20h encrypted payload bytes.
// [RULE9] Rewrite payload: encrypted challenge then encrypted new key.
// [RULE10] Key rewrite answered 87h, 01h, status 00h or 01h.
// [RULE11] Sleep after sixty idle seconds by default.
// [RULE12] Sleep option 0Dh/01h selects 60,90,120,180 s or off.
// [RULE13] Sleep option answered 8Dh, 01h, status byte.
// [RULE14] Address request 0Eh/00h replies 8Eh, 06h, six address bytes.
// [RULE15] Address served only over USB.
// [RULE16] Any request or reply restarts idle; bad sleep value fails.
// [RULE17] Reply opcode is request opcode with top bit set.
`timescale 1ns/1ps
module rpch_core #(
    parameter int     SERIAL_LEN  = 10,
    parameter int     VERSION_LEN = 5,
    parameter logic [SERIAL_LEN*8-1:0]  SERIAL  = '1,
    // Version text "V1.00"; value arbitrary
    parameter logic [VERSION_LEN*8-1:0] VERSION = 40'h56312e3030,
    // Radio address; value arbitrary
    parameter logic [47:0]              RADIO_ADDR = 48'h0a0b0c0d0e0f,
    parameter logic [127:0]             KEY_INIT = '0,
    parameter longint T60  = rpch_pkg::IDLE_60_CYC,
    parameter longint T90  = rpch_pkg::IDLE_90_CYC,
    parameter longint T120 = rpch_pkg::IDLE_120_CYC,
    parameter longint T180 = rpch_pkg::IDLE_180_CYC
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_link_wireless,
    input  wire logic         i_req_valid,
    input  wire logic [7:0]   i_req_data,
    input  wire logic         i_req_last,
    output logic              o_req_ready,
    output logic              o_rep_valid,
    output logic [7:0]        o_rep_data,
    output logic              o_rep_last,
    input  wire logic         i_rep_ready,
    output logic              o_key_check_valid,
    output logic [127:0]      o_key_check_cipher,
    output logic [127:0]      o_key_check_challenge,
    output logic [127:0]      o_key_check_new_cipher,
    input  wire logic         i_key_check_done,
    input  wire logic         i_key_check_ok,
    input  wire logic [127:0] i_key_check_new_key,
    output logic [127:0]      o_master_key,
    output logic              o_sleep
);
    typedef enum {
        RPCH_RX, RPCH_CHECK, RPCH_TX
    } rpch_state_t;

    localparam int BUF_LEN = 34;
    localparam int REP_MAX = 18;

    rpch_state_t  state;
    logic [7:0]   rx_buf [BUF_LEN];
    logic [7:0]   tx_buf [REP_MAX];
    logic [5:0]   rx_idx;
    logic [4:0]   tx_idx;
    logic [4:0]   tx_len;
    logic [31:0]  lfsr;
    logic [31:0]  lfsr_rot;
    logic [31:0]  lfsr_mix;
    logic [127:0] challenge;
    logic         chal_ok;
    logic [127:0] master_key;
    logic [7:0]   opcode;
    logic [7:0]   count;
    logic         accept;
    logic         send;

    rpch_sleep_if sl ();

    rpch_idle_timer #(
        .T60  (T60),
        .T90  (T90),
        .T120 (T120),
        .T180 (T180)
    ) u_timer (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .sl    (sl)
    );

    assign opcode      = rx_buf[rpch_pkg::OFS_OPCODE];
    assign count       = rx_buf[rpch_pkg::OFS_COUNT];
    assign o_req_ready = (state == RPCH_RX);
    assign accept      = i_req_valid && o_req_ready;
    assign send        = o_rep_valid && i_rep_ready;
    assign o_rep_valid = (state == RPCH_TX) && tx_len != 5'h0;
    assign o_rep_data  = tx_buf[tx_idx];
    assign o_rep_last  = (tx_idx == tx_len - 5'h1);
    assign o_master_key = master_key;
    assign o_sleep     = sl.sleep;

    // [RULE16] Requests and replies count as activity
    assign sl.activity = accept || send;

    // ----------------------------------------------------------------
    // Request capture
    // ----------------------------------------------------------------
    // [RULE1] [RULE2] Unwrapped bytes stored by offset
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rx_idx <= 6'h0;
        else if (accept)
            rx_idx <= i_req_last ? 6'h0 : rx_idx + 6'h1;
    end

    // Bytes past the buffer are dropped until rx_idx wraps at 64; later bytes then overwrite the opcode and count bytes
    always_ff @(posedge i_clk)
    begin
        if (accept && rx_idx < 6'(BUF_LEN))
            rx_buf[rx_idx] <= i_req_data;
    end

    // ----------------------------------------------------------------
    // Challenge source
    // ----------------------------------------------------------------
    // Free-running LFSR; a true entropy source would replace it
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            lfsr <= 32'(rpch_pkg::LFSR_SEED);
        else
            lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    end

    assign lfsr_rot = {lfsr[15:0], lfsr[31:16]};
    assign lfsr_mix = lfsr ^ 32'h5a5a5a5a;

    // ----------------------------------------------------------------
    // Sequencer and reply build
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            state <= RPCH_RX;
        else
            case (state)
                RPCH_RX:
                    if (accept && i_req_last)
                        state <= RPCH_CHECK;
                RPCH_CHECK:
                    if (opcode != rpch_pkg::OP_KEY || count !=
                        rpch_pkg::LEN_KEY || i_key_check_done)
                        state <= RPCH_TX;
                // Refused request leaves an empty reply: one idle cycle
                RPCH_TX:
                    if (tx_len == 5'h0 || send && o_rep_last)
                        state <= RPCH_RX;
                default:
                    state <= RPCH_RX;
            endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst || state == RPCH_RX)
            tx_idx <= 5'h0;
        else if (send)
            tx_idx <= tx_idx + 5'h1;
    end

    // [RULE5] [RULE9] Key check sees challenge and new key halves
    always_comb
    begin
        o_key_check_valid = (state == RPCH_CHECK) && tx_len == 5'h0 &&
                            opcode == rpch_pkg::OP_KEY &&
                            count == rpch_pkg::LEN_KEY;
        o_key_check_challenge = challenge;
        for (int i = 0; i < 16; i++)
        begin
            o_key_check_cipher[127-8*i -: 8]     = rx_buf[2+i];
            o_key_check_new_cipher[127-8*i -: 8] = rx_buf[18+i];
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            master_key <= KEY_INIT;
        // [RULE8] Only a checked rewrite changes key
        else if (o_key_check_valid && i_key_check_done && i_key_check_ok
                 && chal_ok)
            master_key <= i_key_check_new_key;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            challenge <= '0;
            chal_ok   <= 1'b0;
        end
        else if (state == RPCH_CHECK && tx_len == 5'h0 &&
                 opcode == rpch_pkg::OP_CHAL && count ==
                 rpch_pkg::LEN_NONE && i_link_wireless)
        begin
            challenge <= {lfsr, ~lfsr, lfsr_rot, lfsr_mix};
            chal_ok   <= 1'b1;
        end
        // Challenge is single use
        else if (o_key_check_valid && i_key_check_done)
            chal_ok <= 1'b0;
    end

    always_ff @(posedge i_clk)
    begin
        sl.load <= 1'b0;
        sl.sel  <= 3'h0;
        if (i_rst || state != RPCH_CHECK)
            tx_len <= (state == RPCH_TX) ? tx_len : 5'h0;
        else if (tx_len == 5'h0)
        begin
            // [RULE17] Reply opcode has top bit set
            tx_buf[rpch_pkg::OFS_OPCODE] <= opcode | rpch_pkg::REPLY_BIT;
            case (opcode)
                // [RULE3] Serial number reply
                rpch_pkg::OP_SERIAL:
                    if (count == rpch_pkg::LEN_NONE)
                    begin
                        tx_buf[1] <= 8'(SERIAL_LEN);
                        for (int i = 0; i < SERIAL_LEN; i++)
                            tx_buf[2+i] <= SERIAL[SERIAL_LEN*8-1-8*i -: 8];
                        tx_len <= 5'(SERIAL_LEN + 2);
                    end
                // [RULE4] [RULE6] Challenge over wireless only
                rpch_pkg::OP_CHAL:
                    if (count == rpch_pkg::LEN_NONE && i_link_wireless)
                    begin
                        tx_buf[1] <= rpch_pkg::LEN_CHAL;
                        for (int i = 0; i < 4; i++)
                        begin
                            tx_buf[2+i]  <= lfsr[31-8*i -: 8];
                            tx_buf[6+i]  <= ~lfsr[31-8*i -: 8];
                            tx_buf[10+i] <= lfsr_rot[31-8*i -: 8];
                            tx_buf[14+i] <= lfsr_mix[31-8*i -: 8];
                        end
                        tx_len <= 5'h12;
                    end
                // [RULE7] Version string reply
                rpch_pkg::OP_VERSION:
                    if (count == rpch_pkg::LEN_NONE)
                    begin
                        tx_buf[1] <= 8'(VERSION_LEN);
                        for (int i = 0; i < VERSION_LEN; i++)
                            tx_buf[2+i] <= VERSION[VERSION_LEN*8-1-8*i -: 8];
                        tx_len <= 5'(VERSION_LEN + 2);
                    end
                // [RULE10] Rewrite status after check
                rpch_pkg::OP_KEY:
                    if (count == rpch_pkg::LEN_KEY && i_key_check_done)
                    begin
                        tx_buf[1] <= rpch_pkg::LEN_ONE;
                        tx_buf[2] <= (i_key_check_ok && chal_ok) ?
                                     rpch_pkg::ST_OK : rpch_pkg::ST_FAIL;
                        tx_len <= 5'h3;
                    end
                // [RULE13] Sleep option status reply
                rpch_pkg::OP_SLEEP:
                    if (count == rpch_pkg::LEN_ONE)
                    begin
                        tx_buf[1] <= rpch_pkg::LEN_ONE;
                        // [RULE16] Values above 04h fail
                        if (rx_buf[2] <= rpch_pkg::SLEEP_OFF)
                        begin
                            tx_buf[2] <= rpch_pkg::ST_OK;
                            // [RULE12] Store selected interval
                            sl.load   <= 1'b1;
                            sl.sel    <= rx_buf[2][2:0];
                        end
                        else
                            tx_buf[2] <= rpch_pkg::ST_FAIL;
                        tx_len <= 5'h3;
                    end
                // [RULE14] [RULE15] Address over USB only
                rpch_pkg::OP_ADDR:
                    if (count == rpch_pkg::LEN_NONE && !i_link_wireless)
                    begin
                        tx_buf[1] <= rpch_pkg::LEN_ADDR;
                        for (int i = 0; i < 6; i++)
                            tx_buf[2+i] <= RADIO_ADDR[47-8*i -: 8];
                        tx_len <= 5'h8;
                    end
                default:
                    tx_len <= 5'h0;
            endcase
        end
    end
endmodule : rpch_core

/* File: core/rpch_idle_timer.sv */
// Idle-sleep countdown with selectable interval.
// Assumes activity pulses are synchronous to i_clk.
`timescale 1ns/1ps
module rpch_idle_timer #(
    parameter longint T60  = rpch_pkg::IDLE_60_CYC,
    parameter longint T90  = rpch_pkg::IDLE_90_CYC,
    parameter longint T120 = rpch_pkg::IDLE_120_CYC,
    parameter longint T180 = rpch_pkg::IDLE_180_CYC
) (
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    rpch_sleep_if.timer sl
);
    logic [2:0]  sel;
    logic [31:0] count;
    logic [31:0] limit;
    logic        sleep_q;

    always_comb
    begin
        case (sel)
            3'h1:    limit = 32'(T90);
            3'h2:    limit = 32'(T120);
            3'h3:    limit = 32'(T180);
            default: limit = 32'(T60);
        endcase
    end

    // [RULE11] Default sixty seconds
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            sel <= 3'h0;
        else if (sl.load)
            sel <= sl.sel;
    end

    // [RULE16] Activity restarts countdown
    always_ff @(posedge i_clk)
    begin
        if (i_rst || sl.activity || sl.load)
            count <= 32'h0;
        else if (count < limit)
            count <= count + 32'h1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst || sl.activity)
            sleep_q <= 1'b0;
        // [RULE12] Value four disables sleep
        else if (sel == 3'h4)
            sleep_q <= 1'b0;
        else if (count + 32'h1 >= limit)
            sleep_q <= 1'b1;
    end

    assign sl.sleep = sleep_q;
endmodule : rpch_idle_timer

/* File: core/rpch_pkg.sv */
// Package for the reader peripheral command handler: opcodes, lengths,
// sleep option codes and timing counts.
// Assumes a 20 MHz system clock.
package rpch_pkg;

    localparam logic [7:0] ESC_WIRELESS_CODE = 8'h6b;

    localparam int OFS_OPCODE  = 0;
    localparam int OFS_COUNT   = 1;
    localparam int OFS_PAYLOAD = 2;

    localparam logic [7:0] OP_SERIAL   = 8'h02;
    localparam logic [7:0] OP_CHAL     = 8'h03;
    localparam logic [7:0] OP_VERSION  = 8'h04;
    localparam logic [7:0] OP_KEY      = 8'h07;
    localparam logic [7:0] OP_SLEEP    = 8'h0d;
    localparam logic [7:0] OP_ADDR     = 8'h0e;
    localparam logic [7:0] REPLY_BIT   = 8'h80;

    localparam logic [7:0] LEN_NONE    = 8'h00;
    localparam logic [7:0] LEN_ONE     = 8'h01;
    localparam logic [7:0] LEN_CHAL    = 8'h10;
    localparam logic [7:0] LEN_KEY     = 8'h20;
    localparam logic [7:0] LEN_ADDR    = 8'h06;

    localparam logic [7:0] ST_OK       = 8'h00;
    localparam logic [7:0] ST_FAIL     = 8'h01;

    localparam logic [7:0] SLEEP_60    = 8'h00;
    localparam logic [7:0] SLEEP_90    = 8'h01;
    localparam logic [7:0] SLEEP_120   = 8'h02;
    localparam logic [7:0] SLEEP_180   = 8'h03;
    localparam logic [7:0] SLEEP_OFF   = 8'h04;

    localparam int CLK_HZ          = 20_000_000;
    localparam int IDLE_60_S       = 60;
    localparam int IDLE_90_S       = 90;
    localparam int IDLE_120_S      = 120;
    localparam int IDLE_180_S      = 180;
    localparam longint IDLE_60_CYC  = longint'(IDLE_60_S) * CLK_HZ;
    localparam longint IDLE_90_CYC  = longint'(IDLE_90_S) * CLK_HZ;
    localparam longint IDLE_120_CYC = longint'(IDLE_120_S) * CLK_HZ;
    localparam longint IDLE_180_CYC = longint'(IDLE_180_S) * CLK_HZ;

    localparam int LFSR_SEED       = 32'h1;

    typedef enum logic [1:0] {
        RPCH_LINK_USB,
        RPCH_LINK_WIRELESS
    } rpch_link_t;

endpackage : rpch_pkg

/* File: core/rpch_sleep_if.sv */
// Interface between the command core and the idle-sleep timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rpch_sleep_if;
    logic       activity;
    logic       load;
    logic [2:0] sel;
    logic       sleep;

    modport ctrl  (output activity, output load, output sel, input sleep);
    modport timer (input activity, input load, input sel, output sleep);
endinterface : rpch_sleep_if

/* File: test/rpch_core_asserts.sv */
// Checker for the command handler, watching the top ports only.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
module rpch_core_asserts #(
    parameter longint T60 = 100
) (
    input wire logic         i_clk,
    input wire logic         i_rst,
    input wire logic         i_link_wireless,
    input wire logic         i_req_valid,
    input wire logic [7:0]   i_req_data,
    input wire logic         i_req_last,
    input wire logic         o_req_ready,
    input wire logic         o_rep_valid,
    input wire logic [7:0]   o_rep_data,
    input wire logic         o_rep_last,
    input wire logic         i_rep_ready,
    input wire logic         o_key_check_valid,
    input wire logic         i_key_check_done,
    input wire logic         o_sleep
);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic       req_first;
    logic       rep_first;
    logic [7:0] req_op;
    longint     idle;
    wire take = i_req_valid && o_req_ready;
    wire give = o_rep_valid && i_rep_ready;
    wire done = take && i_req_last;

    always_ff @(posedge i_clk)
    begin
        if (i_rst) req_first <= 1'b1;
        else if (take) req_first <= i_req_last;
    end
    always_ff @(posedge i_clk)
    begin
        if (take && req_first) req_op <= i_req_data;
    end
    always_ff @(posedge i_clk)
    begin
        if (i_rst) rep_first <= 1'b1;
        else if (give) rep_first <= o_rep_last;
    end
    // Mirrors the restart on every byte moved either way
    always_ff @(posedge i_clk)
    begin
        if (i_rst || take || give) idle <= 0;
        else idle <= idle + 1;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_reset_values: assert property (disable iff (1'b0)
        i_rst |=> o_req_ready && !o_rep_valid && !o_sleep)
        else $error("outputs not at reset values");
    a_reply_holds: assert property (
        o_rep_valid && !i_rep_ready |=> o_rep_valid && $stable(o_rep_data))
        else $error("reply byte changed while stalled");
    a_ready_drops: assert property (
        done |=> !o_req_ready [*2])
        else $error("request taken during processing");
    a_reply_opcode: assert property (
        rep_first && o_rep_valid |-> o_rep_data == (req_op | 8'h80))
        else $error("reply opcode lacks top bit");
    a_reply_soon: assert property (
        done && req_op != 8'h07 |-> ##[1:3] (o_rep_valid || o_req_ready))
        else $error("no reply or ready after request");
    a_refused_link: assert property (
        done && !req_first && (req_op == 8'h03 && !i_link_wireless ||
        req_op == 8'h0e && i_link_wireless) |=> !o_rep_valid [*4])
        else $error("request served on wrong link");
    a_key_waits: assert property (
        o_key_check_valid && !i_key_check_done |=> !o_rep_valid)
        else $error("rewrite answered before check done");
    a_sleep_idle: assert property (
        $rose(o_sleep) |-> idle >= T60 - 3)
        else $error("sleep entered too early");

    c_reply: cover property (give && o_rep_last);
    c_key: cover property (o_key_check_valid && i_key_check_done);
    c_sleep: cover property ($rose(o_sleep));
endmodule : rpch_core_asserts

bind rpch_core rpch_core_asserts #(.T60(T60)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_link_wireless(i_link_wireless),
    .i_req_valid(i_req_valid), .i_req_data(i_req_data),
    .i_req_last(i_req_last), .o_req_ready(o_req_ready),
    .o_rep_valid(o_rep_valid), .o_rep_data(o_rep_data),
    .o_rep_last(o_rep_last), .i_rep_ready(i_rep_ready),
    .o_key_check_valid(o_key_check_valid),
    .i_key_check_done(i_key_check_done), .o_sleep(o_sleep));

/* File: test/rpch_host_model.sv */
// Host side model: reply sink and external key check responder.
// Assumes the same clock as the command core.
`timescale 1ns/1ps
module rpch_host_model (
    input  wire logic         i_clk,
    input  wire logic         i_slow,
    input  wire logic         i_ok,
    input  wire logic [127:0] i_new_key,
    input  wire logic         i_check_valid,
    output logic              o_rep_ready,
    output logic              o_done,
    output logic              o_ok,
    output logic [127:0]      o_new_key
);
    logic [2:0] tick = 3'h0;
    wire hit = i_check_valid && !o_done && tick == 3'h7;

    always_ff @(posedge i_clk) tick <= tick + 3'h1;
    // Slow mode stalls three cycles in four
    assign o_rep_ready = !i_slow || tick[1:0] == 2'h0;
    always_ff @(posedge i_clk)
    begin
        o_done    <= hit;
        // Result lines show junk outside the done pulse
        o_ok      <= hit ? i_ok : tick[0];
        o_new_key <= hit ? i_new_key : {32{tick[0], tick}};
    end
endmodule : rpch_host_model

/* File: test/tb.sv */
// Self-checking bench for the peripheral command handler.
// Assumes shortened idle counts and the host model as far side.
`timescale 1ns/1ps
module tb;
    typedef logic [7:0] rpch_q_t[$];
    localparam longint TMO [4] = '{100, 150, 200, 300};
    localparam logic [39:0] VER = 40'h56322e3135;
    // Radio address; value arbitrary
    localparam logic [47:0] ADDR = 48'h112233445566;
    logic         i_clk = 1'b0;
    logic         i_rst = 1'b1;
    logic         i_link_wireless = 1'b0;
    logic         i_req_valid = 1'b0;
    logic         i_req_last = 1'b0;
    logic [7:0]   i_req_data = 8'h00;
    logic         slow = 1'b0;
    logic         ok = 1'b0;
    logic [127:0] new_key = '0;
    logic [127:0] key = '0;
    logic [127:0] nk;
    logic         i_rep_ready, i_key_check_done, i_key_check_ok;
    logic         o_req_ready, o_rep_valid, o_rep_last;
    logic         o_key_check_valid, o_sleep;
    logic [7:0]   o_rep_data;
    logic [127:0] i_key_check_new_key, o_master_key;
    logic [127:0] cip, ncip, chal;
    int           n_mismatch = 0;
    int           total_checks = 0;
    int           cycles = 0;
    rpch_q_t      got;
    rpch_q_t      req;
    rpch_q_t      chq;

    rpch_core #(.VERSION(VER), .RADIO_ADDR(ADDR), .T60(TMO[0]),
        .T90(TMO[1]), .T120(TMO[2]), .T180(TMO[3])) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_link_wireless(i_link_wireless),
        .i_req_valid(i_req_valid), .i_req_data(i_req_data),
        .i_req_last(i_req_last), .o_req_ready(o_req_ready),
        .o_rep_valid(o_rep_valid), .o_rep_data(o_rep_data),
        .o_rep_last(o_rep_last), .i_rep_ready(i_rep_ready),
        .o_key_check_valid(o_key_check_valid), .o_key_check_cipher(cip),
        .o_key_check_challenge(chal), .o_key_check_new_cipher(ncip),
        .i_key_check_done(i_key_check_done),
        .i_key_check_ok(i_key_check_ok),
        .i_key_check_new_key(i_key_check_new_key),
        .o_master_key(o_master_key), .o_sleep(o_sleep));

    rpch_host_model host (.i_clk(i_clk), .i_slow(slow), .i_ok(ok),
        .i_new_key(new_key), .i_check_valid(o_key_check_valid),
        .o_rep_ready(i_rep_ready), .o_done(i_key_check_done),
        .o_ok(i_key_check_ok), .o_new_key(i_key_check_new_key));

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    function automatic rpch_q_t rep(input logic [7:0] op,
                                    input rpch_q_t pl);
        rep = {op | 8'h80, 8'(pl.size())};
        foreach (pl[i]) rep.push_back(pl[i]);
    endfunction : rep

    function automatic rpch_q_t msb(input logic [127:0] v, input int n);
        msb = {};
        for (int i = n - 1; i >= 0; i--) msb.push_back(v[8*i+:8]);
    endfunction : msb

    task automatic do_reset();
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
    endtask : do_reset

    task automatic send(input rpch_q_t q);
        for (int i = 0; i < q.size(); i++)
        begin
            i_req_valid <= 1'b1;
            i_req_data  <= q[i];
            i_req_last  <= (i == q.size() - 1);
            // Ready only moves on a rising edge, so sample it mid-cycle
            do @(negedge i_clk); while (o_req_ready !== 1'b1);
            @(posedge i_clk);
        end
        i_req_valid <= 1'b0;
    endtask : send

    task automatic recv(output rpch_q_t q);
        q = {};
        for (int n = 0; n < 128; n++)
        begin
            @(negedge i_clk);
            if (o_rep_valid === 1'b1 && i_rep_ready === 1'b1)
            begin
                q.push_back(o_rep_data);
                if (o_rep_last === 1'b1) break;
            end
        end
        @(posedge i_clk);
    endtask : recv

    task automatic take_reply(input rpch_q_t exp);
        recv(got);
        check(8'(got.size()), 8'(exp.size()));
        foreach (exp[i])
            check(i < got.size() ? got[i] : ~exp[i], exp[i]);
    endtask : take_reply

    task automatic xact(input rpch_q_t rq, input rpch_q_t exp);
        send(rq);
        take_reply(exp);
    endtask : xact

    task automatic drop(input rpch_q_t rq);
        logic seen;
        seen = 1'b0;
        send(rq);
        repeat (4)
        begin
            @(negedge i_clk);
            seen |= o_rep_valid;
        end
        check({7'h0, seen}, 8'h00);
        check({7'h0, o_req_ready}, 8'h01);
        @(posedge i_clk);
    endtask : drop

    task automatic sleep_wait(input longint t);
        longint n;
        n = 0;
        while (o_sleep !== 1'b1 && n < 1000)
        begin
            @(negedge i_clk);
            n++;
        end
        check({7'h0, n >= t - 3 && n <= t + 3}, 8'h01);
        @(posedge i_clk);
    endtask : sleep_wait

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h8aa30604));
        do_reset();
        sleep_wait(TMO[0]);
        for (int v = 0; v < 4; v++)
        begin
            do_reset();
            xact({8'h0d, 8'h01, 8'(v)}, rep(8'h0d, {8'h00}));
            sleep_wait(TMO[v]);
        end
        do_reset();
        xact({8'h0d, 8'h01, 8'h04}, rep(8'h0d, {8'h00}));
        repeat (400) @(negedge i_clk);
        check({7'h0, o_sleep}, 8'h00);
        @(posedge i_clk);
        do_reset();
        req = {8'h0d, 8'h01, 8'($urandom_range(255, 5))};
        xact(req, rep(8'h0d, {8'h01}));
        sleep_wait(TMO[0]);
        // fixed replies with a stalling host
        do_reset();
        slow <= 1'b1;
        xact({8'h02, 8'h00}, rep(8'h02, msb('1, 10)));
        xact({8'h04, 8'h00}, rep(8'h04, msb(VER, 5)));
        xact({8'h0e, 8'h00}, rep(8'h0e, msb(ADDR, 6)));
        drop({8'h03, 8'h00});
        drop({8'h02, 8'h01, 8'h00});
        drop({8'h08, 8'h00});
        i_link_wireless <= 1'b1;
        drop({8'h0e, 8'h00});
        // good rewrite, spent challenge, failed check
        for (int k = 0; k < 3; k++)
        begin
            if (k != 1)
            begin
                send({8'h03, 8'h00});
                recv(chq);
                check(8'(chq.size()), 8'h12);
                check(chq[0], 8'h83);
                check(chq[1], 8'h10);
            end
            nk = {$urandom(), $urandom(), $urandom(), $urandom()};
            new_key <= nk;
            ok <= (k < 2);
            if (k == 0) key = nk;
            req = {8'h07, 8'h20};
            repeat (32) req.push_back(8'($urandom()));
            send(req);
            // Check inputs stand while the rewrite waits for the host
            @(negedge i_clk);
            for (int i = 0; i < 16; i++)
            begin
                check(chal[127-8*i-:8], chq[2+i]);
                check(cip[127-8*i-:8], req[2+i]);
                check(ncip[127-8*i-:8], req[18+i]);
            end
            take_reply(rep(8'h07, {8'(k != 0)}));
            for (int i = 0; i < 16; i++)
                check(o_master_key[8*i+:8], key[8*i+:8]);
        end
        final_report();
    end
endmodule : tb
